// file: rtl/plc_pkg.sv
// package: constants, register map and types of the per-port phy link control block
// Notes on behaviour
// - time base takes 25 or 50 MHz reference, gives 25 MHz transmit clock in 100 mode.
// - in 10 mode time base gives 2.5 MHz transmit clock plus oversampling clock.
// - 10 mode link status follows reception of valid link pulses.
// - 100 copper mode link comes up on received scrambled idles.
// - fiber mode on fiber-capable ports takes link from the fiber signal detect input.
// - force link good bit makes link good and bypasses the link monitor.
// - pulse checking off only with negotiation disabled and pulse check disable set.
// - link pulse transmission stops with negotiation disabled and pulse gen disable set; energy sense sleep pulses still go out.
// - negotiation starts on resets, restart bit, power-up, or link fail to up.
// - partner without negotiation: parallel detect finds speed, duplex fixed at half.
// - negotiation disabled: speed and duplex from control bits, abilities from advertisement.
// - enable, speed, duplex writes take effect on reset, restart, power-up or link loss.
// - advertisement captured once on each entry into ability detect.
// - next page transmit register captured once on each entry into next page exchange.
// - received pages go to partner ability; with redirect set next pages go elsewhere.
// - on completion update speed, duplex, page received, complete in specific status; complete also in basic status.
// - power down ignores mac signals except management and all cable activity.
// - power down is left only when software clears the power down bit.
// - energy sense mode sends one link pulse per second and wakes on energy; the timers assume a 50 MHz clock, so one every 2 s with a 25 MHz reference.
// - energy sense setting kept after wake; sleeps again on link and energy loss.
// - far fault on a fiber port sends 84 ones then one zero, repeated.
// - far fault disable resets to 0 only for a fiber port with strap 1, else 1.
package plc_pkg;
	localparam int ADDR_W = 5;
	localparam int DATA_W = 16;

	// ************************************************************
	// register offsets (word index)
	// ************************************************************
	localparam logic [4:0] REG_CTRL  = 5'h00;
	localparam logic [4:0] REG_STAT  = 5'h01;
	localparam logic [4:0] REG_ADV   = 5'h04;
	localparam logic [4:0] REG_LPA   = 5'h05;
	localparam logic [4:0] REG_NPTX  = 5'h07;
	localparam logic [4:0] REG_LPNP  = 5'h08;
	localparam logic [4:0] REG_SCTL  = 5'h10;
	localparam logic [4:0] REG_SSTAT = 5'h11;

	// control bits
	localparam int C_SWRST = 15;
	localparam int C_SPEED = 13;
	localparam int C_ANEN  = 12;
	localparam int C_PDOWN = 11;
	localparam int C_RESTART = 9;
	localparam int C_DUPLEX = 8;
	// specific control bits
	localparam int S_DISFF  = 0;
	localparam int S_DISSCR = 1;
	localparam int S_DISGEN = 2;
	localparam int S_DISCHK = 3;
	localparam int S_REDIR  = 4;
	localparam int S_ENERGY_SENSE_ENABLE_BIT   = 5;
	localparam int S_FORCE  = 10;
	// page bits
	localparam int P_NP   = 15;
	localparam int P_TXFD = 8;
	localparam int P_TXHD = 7;
	localparam int P_10FD = 6;

	localparam logic [15:0] CTRL_RST = 16'h3100;
	localparam logic [15:0] ADV_RST  = 16'h01e1;
	localparam logic [15:0] NPTX_RST = 16'h0001;

	// ************************************************************
	// time base dividers, in cycles of the reference
	// ************************************************************
	localparam logic [4:0] DIV_TX100_50 = 5'h02;
	localparam logic [4:0] DIV_TX100_25 = 5'h01;
	localparam logic [4:0] DIV_TX10_50  = 5'h14;
	localparam logic [4:0] DIV_TX10_25  = 5'h0a;
	localparam logic [4:0] DIV_OS_50    = 5'h0a;
	localparam logic [4:0] DIV_OS_25    = 5'h05;

	localparam logic [6:0] FAR_FAULT_INDICATION_ONES = 7'h54;

	// ************************************************************
	// timing
	// ************************************************************
	localparam int CLK_KHZ      = 50000;
	localparam int NLP_GAP_MS   = 16;
	localparam int LINK_LOSS_MS = 100;
	localparam int ED_PERIOD_MS = 1000;
	localparam int NLP_GAP_CYC   = NLP_GAP_MS * CLK_KHZ;
	localparam int LINK_LOSS_CYC = LINK_LOSS_MS * CLK_KHZ;
	localparam int ED_PERIOD_CYC = ED_PERIOD_MS * CLK_KHZ;

	typedef enum logic [1:0] {AN_OFF, AN_ABILITY, AN_NEXT_PAGE, AN_DONE} plc_an_e;
endpackage : plc_pkg

// file: rtl/plc_time_base.sv
// time base: transmit clock and oversampling enables from the reference clock
`timescale 1ns/1ps
module plc_time_base import plc_pkg::*; (
	input  wire logic clock,         // reference clock
	input  wire logic rst,           // sync reset
	input  wire logic ref_is_25,     // reference runs at 25 MHz
	input  wire logic speed100,      // 100 Mb/s operation
	output logic      mac_tx_clk_en, // transmit clock enable
	output logic      os_clk_en      // oversampling enable
);
	logic [4:0] tx_cnt_q;
	logic [4:0] os_cnt_q;
	wire  [4:0] tx_div;
	wire  [4:0] os_div;
	wire        tx_wrap;
	wire        os_wrap;

	assign tx_div = speed100 ? (ref_is_25 ? DIV_TX100_25 : DIV_TX100_50)
	                         : (ref_is_25 ? DIV_TX10_25 : DIV_TX10_50);
	assign os_div  = ref_is_25 ? DIV_OS_25 : DIV_OS_50;
	// >= so a speed change mid-count never overruns the new period
	assign tx_wrap = tx_cnt_q >= tx_div - 5'h01;
	assign os_wrap = os_cnt_q >= os_div - 5'h01;

	always_ff @(posedge clock) begin
		if (rst) begin
			tx_cnt_q      <= 5'h00;
			os_cnt_q      <= 5'h00;
			mac_tx_clk_en <= 1'b0;
			os_clk_en     <= 1'b0;
		end else begin
			tx_cnt_q      <= tx_wrap ? 5'h00 : tx_cnt_q + 5'h01;
			os_cnt_q      <= os_wrap ? 5'h00 : os_cnt_q + 5'h01;
			mac_tx_clk_en <= tx_wrap;
			os_clk_en     <= os_wrap;
		end
	end
endmodule : plc_time_base

// file: rtl/plc_far_fault_gen.sv
// fiber idle stream generator with far fault pattern
`timescale 1ns/1ps
module plc_far_fault_gen import plc_pkg::*; (
	input  wire logic clock,    // system clock
	input  wire logic rst,      // sync reset
	input  wire logic sym_en,   // one enable per idle bit
	input  wire logic fault_on, // far fault to be signalled
	output logic      idle_bit  // idle stream bit
);
	logic [6:0] ones_q;

	always_ff @(posedge clock) begin
		if (rst) begin
			ones_q   <= 7'h00;
			idle_bit <= 1'b1;
		end else if (sym_en) begin
			if (fault_on && ones_q == FAR_FAULT_INDICATION_ONES) begin
				idle_bit <= 1'b0;
				ones_q   <= 7'h00;
			end else begin
				idle_bit <= 1'b1;
				ones_q   <= fault_on ? ones_q + 7'h01 : 7'h00;
			end
		end
	end
endmodule : plc_far_fault_gen

// file: rtl/plc_port.sv
// per-port link monitor, negotiation control, power modes and far fault control
`timescale 1ns/1ps
module plc_port import plc_pkg::*; #(
	parameter bit FIBER_CAPABLE = 1'b1,          // only ports 0 and 1 carry fiber
	parameter int NLP_GAP       = NLP_GAP_CYC,   // normal link pulse spacing
	parameter int LINK_LOSS     = LINK_LOSS_CYC, // pulse silence before link fail
	parameter int ED_PERIOD     = ED_PERIOD_CYC  // sleep pulse spacing
) (
	input  wire logic              clock,               // 25 or 50 MHz reference, per ref_is_25
	input  wire logic              rst,                 // sync reset, active high
	input  wire logic              ref_is_25,           // reference strap: 25 MHz
	input  wire logic              fiber_strap,         // port configured for fiber
	input  wire logic              fault_strap,         // far fault configuration strap
	input  wire logic              energy_sense_strap,  // low power strap
	input  wire logic [ADDR_W-1:0] reg_addr,            // register index
	input  wire logic [DATA_W-1:0] reg_wdata,           // write data
	input  wire logic              reg_wr,              // write strobe
	input  wire logic              reg_rd,              // read strobe
	output logic      [DATA_W-1:0] reg_rdata,           // read data, cycle after strobe
	input  wire logic              rx_nlp,              // valid link pulse seen
	input  wire logic              rx_idle_lock,        // scrambled idles locked
	input  wire logic              fiber_signal_detect, // optical receiver detect
	input  wire logic              energy_present,      // energy on the wire
	input  wire logic              rx_page_valid,       // partner page received
	input  wire logic [15:0]       rx_page,             // partner page word
	input  wire logic              legacy_detect,       // partner not negotiating
	input  wire logic              legacy_speed100,     // legacy partner is 100
	input  wire logic              remote_fault,        // remote fault detected
	input  wire logic              mac_tx_en_in,        // transmit enable from mac
	output logic                   mac_tx_en,           // gated transmit enable
	output logic                   mac_tx_clk_en,       // mac transmit clock enable
	output logic                   os_clk_en,           // oversampling enable
	output logic                   nlp_tx,              // send one link pulse
	output logic                   flp_tx_en,           // send fast link pulses
	output logic      [15:0]       tx_page,             // page being sent
	output logic                   link_up,             // link status
	output logic                   speed100,            // operating at 100
	output logic                   full_duplex,         // operating full duplex
	output logic                   scrambler_on,        // scrambler enabled
	output logic                   fiber_idle_bit       // fiber idle stream bit
);
	// ************************************************************
	// registers and state
	// ************************************************************
	logic [15:0] ctrl_q;
	logic [15:0] adv_q;
	logic [15:0] nptx_q;
	logic [15:0] sctl_q;
	logic [15:0] lpa_q;
	logic [15:0] lpnp_q;
	logic [15:0] adv_lat_q;
	logic [15:0] np_lat_q;
	logic        aneg_eff_q;
	logic        spd_eff_q;
	logic        dup_eff_q;
	logic        hcd_spd_q;
	logic        hcd_dup_q;
	logic        pg_rx_q;
	logic        done_q;
	logic        link_q;
	logic        sleep_q;
	logic [31:0] loss_cnt_q;
	logic [31:0] gap_cnt_q;
	plc_an_e     an_q;
	plc_an_e     an_d;

	// ************************************************************
	// decode
	// ************************************************************
	wire fiber    = FIBER_CAPABLE & fiber_strap;
	wire pd       = ctrl_q[C_PDOWN];
	wire wr_ctrl  = reg_wr & (reg_addr == REG_CTRL);
	wire wr_sctl  = reg_wr & (reg_addr == REG_SCTL);
	wire rd_sstat = reg_rd & (reg_addr == REG_SSTAT);
	wire sw_rst   = wr_ctrl & reg_wdata[C_SWRST];
	wire restart  = wr_ctrl & reg_wdata[C_RESTART];
	// only software can clear power down; no cable event reaches this bit
	wire pd_wake  = wr_ctrl & pd & ~reg_wdata[C_PDOWN];
	wire idle     = pd | sleep_q;

	// cable inputs other than energy_present are ignored while powered down or asleep
	wire nlp_g    = rx_nlp & ~idle;
	wire lock_g   = rx_idle_lock & ~idle;
	wire fiber_signal_detect_g   = fiber_signal_detect & ~idle;
	wire page_g   = rx_page_valid & ~idle;
	wire legacy_g = legacy_detect & ~idle;
	wire fault_g  = remote_fault & ~idle;

	// ************************************************************
	// link monitor
	// ************************************************************
	wire chk_off  = ~aneg_eff_q & sctl_q[S_DISCHK];
	wire nlp_ok   = chk_off | (loss_cnt_q < 32'(LINK_LOSS));
	wire mon_link = fiber    ? fiber_signal_detect_g :
	                speed100 ? lock_g : nlp_ok;
	wire link_raw = sctl_q[S_FORCE] | (mon_link & ~idle);
	wire link_rise = link_raw & ~link_q;
	wire link_lost = ~link_raw & link_q;

	// ************************************************************
	// negotiation start and deferred settings
	// ************************************************************
	wire apply  = sw_rst | restart | pd_wake | link_lost;
	wire start  = sw_rst | restart | pd_wake | link_rise;
	wire [15:0] ctl_src = wr_ctrl ? reg_wdata : ctrl_q;
	wire aneg_nx = apply ? ctl_src[C_ANEN] : aneg_eff_q;
	wire an_on   = aneg_nx & ~fiber;

	// highest common ability of the base pages
	wire [15:0] common = adv_lat_q & rx_page;
	wire        res_100 = common[P_TXFD] | common[P_TXHD];
	wire        res_fd  = res_100 ? common[P_TXFD] : common[P_10FD];
	wire        more_np = adv_lat_q[P_NP] & rx_page[P_NP];

	always_comb begin
		an_d = an_q;
		if (start) begin
			an_d = an_on ? AN_ABILITY : AN_OFF;
		end else begin
			unique case (an_q)
				AN_OFF: begin
					an_d = AN_OFF;
				end
				AN_ABILITY: begin
					if (page_g) begin
						an_d = more_np ? AN_NEXT_PAGE : AN_DONE;
					end else if (legacy_g) begin
						an_d = AN_DONE;
					end
				end
				AN_NEXT_PAGE: begin
					if (page_g && !rx_page[P_NP]) begin
						an_d = AN_DONE;
					end
				end
				AN_DONE: begin
					an_d = AN_DONE;
				end
			endcase
		end
	end

	wire enter_ab = (an_d == AN_ABILITY) & (start | an_q != AN_ABILITY);
	wire enter_np = (an_d == AN_NEXT_PAGE) & (an_q != AN_NEXT_PAGE);
	wire enter_dn = (an_d == AN_DONE) & (an_q != AN_DONE);
	wire par_det  = (an_q == AN_ABILITY) & ~page_g & legacy_g;

	always_ff @(posedge clock) begin
		if (rst) begin
			an_q <= AN_ABILITY;
		end else begin
			an_q <= (aneg_eff_q | start) & ~fiber ? an_d : AN_OFF;
		end
	end

	// ************************************************************
	// page capture and resolution
	// ************************************************************
	always_ff @(posedge clock) begin
		if (rst) begin
			adv_lat_q <= ADV_RST;
			np_lat_q  <= NPTX_RST;
			lpa_q     <= 16'h0000;
			lpnp_q    <= 16'h0000;
			hcd_spd_q <= 1'b0;
			hcd_dup_q <= 1'b0;
		end else begin
			if (enter_ab) begin
				adv_lat_q <= adv_q;
			end
			if (enter_np) begin
				np_lat_q <= nptx_q;
			end
			if (page_g && an_q == AN_ABILITY) begin
				lpa_q     <= rx_page;
				hcd_spd_q <= res_100;
				hcd_dup_q <= res_fd;
			end else if (page_g && an_q == AN_NEXT_PAGE) begin
				if (sctl_q[S_REDIR]) begin
					lpnp_q <= rx_page;
				end else begin
					lpa_q <= rx_page;
				end
			end else if (par_det) begin
				hcd_spd_q <= legacy_speed100;
				hcd_dup_q <= 1'b0;
			end
		end
	end

	// ************************************************************
	// operating mode and status
	// ************************************************************
	wire pg_set = page_g & (an_q == AN_ABILITY || an_q == AN_NEXT_PAGE);
	// a base page that ends negotiation resolves in the cycle it is captured
	wire res_spd = par_det ? legacy_speed100 : (an_q == AN_ABILITY) ? res_100 : hcd_spd_q;
	wire res_dup = ~par_det & ((an_q == AN_ABILITY) ? res_fd : hcd_dup_q);

	always_ff @(posedge clock) begin
		if (rst) begin
			aneg_eff_q  <= CTRL_RST[C_ANEN];
			spd_eff_q   <= CTRL_RST[C_SPEED];
			dup_eff_q   <= CTRL_RST[C_DUPLEX];
			speed100    <= CTRL_RST[C_SPEED];
			full_duplex <= 1'b0;
			done_q      <= 1'b0;
			pg_rx_q     <= 1'b0;
			link_q      <= 1'b0;
		end else begin
			link_q <= link_raw;
			if (apply) begin
				aneg_eff_q <= ctl_src[C_ANEN];
				spd_eff_q  <= ctl_src[C_SPEED];
				dup_eff_q  <= ctl_src[C_DUPLEX];
			end
			if (fiber) begin
				speed100    <= 1'b1;
				full_duplex <= dup_eff_q;
			end else if (an_q == AN_OFF) begin
				speed100    <= spd_eff_q;
				full_duplex <= dup_eff_q;
			end else if (enter_dn) begin
				speed100    <= res_spd;
				full_duplex <= res_dup;
			end
			done_q  <= start ? 1'b0 : (done_q | enter_dn);
			// a new page beats the clear-on-read in the same cycle
			pg_rx_q <= pg_set | (pg_rx_q & ~rd_sstat);
		end
	end

	// ************************************************************
	// software registers
	// ************************************************************
	wire [15:0] sctl_rst = {10'h000, energy_sense_strap, 3'h0,
	                        fiber, ~(fiber & fault_strap)};

	always_ff @(posedge clock) begin
		if (rst) begin
			ctrl_q <= CTRL_RST;
			adv_q  <= ADV_RST;
			nptx_q <= NPTX_RST;
			sctl_q <= sctl_rst;
		end else begin
			if (wr_ctrl) begin
				// reset and restart self-clear after acting once
				ctrl_q <= reg_wdata & ~(16'h0001 << C_SWRST) & ~(16'h0001 << C_RESTART);
			end
			if (reg_wr && reg_addr == REG_ADV) begin
				adv_q <= reg_wdata;
			end
			if (reg_wr && reg_addr == REG_NPTX) begin
				nptx_q <= reg_wdata;
			end
			if (wr_sctl) begin
				sctl_q <= reg_wdata;
			end
		end
	end

	wire [15:0] stat_w  = {9'h000, 1'b0, done_q, 1'b0, ~fiber, link_q, 2'h0};
	wire [15:0] sstat_w = {1'b0, speed100, full_duplex, pg_rx_q, done_q, link_q,
	                       sleep_q, 9'h000};

	always_ff @(posedge clock) begin
		if (rst) begin
			reg_rdata <= 16'h0000;
		end else if (reg_rd) begin
			unique case (reg_addr)
				REG_CTRL:  reg_rdata <= ctrl_q;
				REG_STAT:  reg_rdata <= stat_w;
				REG_ADV:   reg_rdata <= adv_q;
				REG_LPA:   reg_rdata <= lpa_q;
				REG_NPTX:  reg_rdata <= nptx_q;
				REG_LPNP:  reg_rdata <= lpnp_q;
				REG_SCTL:  reg_rdata <= sctl_q;
				REG_SSTAT: reg_rdata <= sstat_w;
				default:   reg_rdata <= 16'h0000;
			endcase
		end else begin
			reg_rdata <= 16'h0000;
		end
	end

	// ************************************************************
	// link pulse timers and energy sense sleep
	// ************************************************************
	wire gen_off  = ~aneg_eff_q & sctl_q[S_DISGEN];
	wire ten_mode = ~fiber & ~speed100 & (an_q == AN_OFF || an_q == AN_DONE);
	wire [31:0] gap_lim = sleep_q ? 32'(ED_PERIOD) : 32'(NLP_GAP);
	wire gap_hit  = gap_cnt_q >= gap_lim - 32'h1;
	wire pulse_ok = sleep_q | (ten_mode & ~pd & ~gen_off);

	always_ff @(posedge clock) begin
		if (rst) begin
			loss_cnt_q <= 32'(LINK_LOSS); // no link until a first pulse arrives
			gap_cnt_q  <= 32'h0;
			nlp_tx     <= 1'b0;
			sleep_q    <= 1'b0;
		end else begin
			if (nlp_g) begin
				loss_cnt_q <= 32'h0;
			end else if (loss_cnt_q < 32'(LINK_LOSS)) begin
				loss_cnt_q <= loss_cnt_q + 32'h1;
			end
			gap_cnt_q <= (gap_hit | ~pulse_ok) ? 32'h0 : gap_cnt_q + 32'h1;
			nlp_tx    <= gap_hit & pulse_ok;
			if (sleep_q) begin
				// the setting bit stays as it was; only the sleep state ends
				sleep_q <= ~energy_present & ~pd & sctl_q[S_ENERGY_SENSE_ENABLE_BIT];
			end else begin
				sleep_q <= sctl_q[S_ENERGY_SENSE_ENABLE_BIT] & ~pd & ~link_q & ~energy_present
				           & ~sctl_q[S_FORCE] & ~fiber;
			end
		end
	end

	// ************************************************************
	// mac side, transmit and far fault
	// ************************************************************
	always_ff @(posedge clock) begin
		if (rst) begin
			mac_tx_en <= 1'b0;
			flp_tx_en <= 1'b0;
			tx_page   <= 16'h0000;
		end else begin
			mac_tx_en <= mac_tx_en_in & ~idle & link_raw;
			flp_tx_en <= ~idle & (an_q == AN_ABILITY || an_q == AN_NEXT_PAGE);
			tx_page   <= (an_q == AN_NEXT_PAGE) ? np_lat_q : adv_lat_q;
		end
	end

	assign link_up      = link_q;
	assign scrambler_on = ~sctl_q[S_DISSCR] & speed100 & ~fiber;

	wire sym_en;
	wire fault_on = fiber & ~sctl_q[S_DISFF] & fault_g;

	plc_time_base u_time_base (
		.clock         (clock),
		.rst           (rst),
		.ref_is_25     (ref_is_25),
		.speed100      (speed100),
		.mac_tx_clk_en (sym_en),
		.os_clk_en     (os_clk_en)
	);

	assign mac_tx_clk_en = sym_en;

	plc_far_fault_gen u_far_fault (
		.clock    (clock),
		.rst      (rst),
		.sym_en   (sym_en),
		.fault_on (fault_on),
		.idle_bit (fiber_idle_bit)
	);
endmodule : plc_port

// file: verif/plc_port_props.sv
// checker: port-level properties of the link control port
`timescale 1ns/1ps
module plc_port_props import plc_pkg::*; (
	input wire logic              clock,         // clock
	input wire logic              rst,           // reset
	input wire logic              ref_is_25,     // 25 MHz strap
	input wire logic              fiber_strap,   // fiber strap
	input wire logic              reg_rd,        // read strobe
	input wire logic [DATA_W-1:0] reg_rdata,     // read data
	input wire logic              mac_tx_en_in,  // mac enable in
	input wire logic              mac_tx_en,     // gated enable
	input wire logic              mac_tx_clk_en, // tx clock enable
	input wire logic              os_clk_en,     // oversampling enable
	input wire logic              nlp_tx,        // link pulse
	input wire logic              flp_tx_en,     // negotiating
	input wire logic              speed100,      // 100 mode
	input wire logic              fiber_idle_bit // idle bit
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);
	property p_rd_idle; !$past(reg_rd) |-> reg_rdata == 16'h0000; endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("read data outside read slot");
	property p_tx100; mac_tx_clk_en && speed100 && $past(speed100) && !ref_is_25 |=> !mac_tx_clk_en; endproperty
	a_tx100: assert property (p_tx100) else $error("100 tx clock too fast");
	property p_tx10; mac_tx_clk_en && !speed100 && !ref_is_25 |=> (!mac_tx_clk_en || speed100)[*8]; endproperty
	a_tx10: assert property (p_tx10) else $error("10 tx clock too fast");
	property p_os; os_clk_en && !ref_is_25 |=> (!os_clk_en)[*8]; endproperty
	a_os: assert property (p_os) else $error("oversampling too fast");
	property p_nlp; nlp_tx |=> !nlp_tx; endproperty
	a_nlp: assert property (p_nlp) else $error("link pulse longer than one cycle");
	property p_mac; mac_tx_en |-> $past(mac_tx_en_in); endproperty
	a_mac: assert property (p_mac) else $error("mac enable without request");
	property p_flp; $fell(rst) && !fiber_strap |-> ##[0:2] flp_tx_en; endproperty
	a_flp: assert property (p_flp) else $error("no negotiation after reset");
	property p_ff_fiber; !fiber_idle_bit |-> fiber_strap; endproperty
	a_ff_fiber: assert property (p_ff_fiber) else $error("fault idle on copper");
	property p_ff_zero; !fiber_idle_bit && mac_tx_clk_en |=> fiber_idle_bit; endproperty
	a_ff_zero: assert property (p_ff_zero) else $error("fault zero too long");
endmodule : plc_port_props
bind plc_port plc_port_props plc_port_props_inst (.clock(clock), .rst(rst),
	.ref_is_25(ref_is_25), .fiber_strap(fiber_strap), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
	.mac_tx_en_in(mac_tx_en_in), .mac_tx_en(mac_tx_en), .mac_tx_clk_en(mac_tx_clk_en),
	.os_clk_en(os_clk_en), .nlp_tx(nlp_tx), .flp_tx_en(flp_tx_en), .speed100(speed100),
	.fiber_idle_bit(fiber_idle_bit));

// file: verif/plc_partner.sv
// partner model: link pulses from the remote station
`timescale 1ns/1ps
module plc_partner #(
	parameter int GAP = 15 // cycles between pulses
) (
	input  wire logic clock,         // clock
	input  wire logic active,        // partner connected
	output logic      rx_nlp = 1'b0  // one-cycle link pulse
);
	int cnt_q = 0;
	always_ff @(posedge clock) begin
		cnt_q <= (!active || cnt_q == GAP - 1) ? 0 : cnt_q + 1;
		rx_nlp <= active && cnt_q == GAP - 1;
	end
endmodule : plc_partner

// file: verif/tb_top.sv
// testbench: register-driven scenarios for one link control port
`timescale 1ns/1ps
module tb_top import plc_pkg::*;;
	logic clock = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, fiber_strap = 1'b0;
	logic fault_strap = 1'b0, rx_page_valid = 1'b0, legacy_detect = 1'b0, remote_fault = 1'b0;
	logic mac_tx_en_in = 1'b0, active = 1'b0, rx_nlp, mac_tx_en, mac_tx_clk_en, os_clk_en;
	logic nlp_tx, flp_tx_en, link_up, speed100, full_duplex, scrambler_on, fiber_idle_bit;
	logic ref_is_25 = 1'b0, energy_sense_strap = 1'b0, rx_idle_lock = 1'b0;
	logic legacy_speed100 = 1'b0, fiber_signal_detect = 1'b0, energy_present = 1'b0;
	logic [4:0] reg_addr = 5'h00;
	logic [15:0] reg_wdata = 16'h0000, rx_page = 16'h0000, reg_rdata, tx_page;
	int fail_count = 0, compares = 0, n, z;
	plc_port #(.NLP_GAP(20), .LINK_LOSS(50), .ED_PERIOD(40)) plc_port_inst (.clock(clock),
		.rst(rst), .ref_is_25(ref_is_25), .fiber_strap(fiber_strap),
		.fault_strap(fault_strap), .energy_sense_strap(energy_sense_strap),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .rx_nlp(rx_nlp), .rx_idle_lock(rx_idle_lock),
		.fiber_signal_detect(fiber_signal_detect), .energy_present(energy_present),
		.rx_page_valid(rx_page_valid), .rx_page(rx_page), .legacy_detect(legacy_detect),
		.legacy_speed100(legacy_speed100),
		.remote_fault(remote_fault), .mac_tx_en_in(mac_tx_en_in), .mac_tx_en(mac_tx_en),
		.mac_tx_clk_en(mac_tx_clk_en), .os_clk_en(os_clk_en), .nlp_tx(nlp_tx),
		.flp_tx_en(flp_tx_en), .tx_page(tx_page), .link_up(link_up), .speed100(speed100),
		.full_duplex(full_duplex), .scrambler_on(scrambler_on), .fiber_idle_bit(fiber_idle_bit));
	plc_partner #(.GAP(15)) plc_partner_inst (.clock(clock), .active(active), .rx_nlp(rx_nlp));
	// ************************************************************
	// bus and compare tasks
	// ************************************************************
	task automatic cyc(input int c);
		repeat (c) @(posedge clock);
	endtask : cyc
	task automatic chk(input logic [15:0] g, input logic [15:0] e);
		compares++;
		if (g !== e) begin
			fail_count++;
			$display("mismatch at %0t: got %h expected %h", $time, g, e);
		end
	endtask : chk
	task automatic wr(input logic [4:0] a, input logic [15:0] d);
		@(posedge clock);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clock);
		reg_wr <= 1'b0;
	endtask : wr
	task automatic rdc(input logic [4:0] a, input logic [15:0] e);
		@(posedge clock);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clock);
		reg_rd <= 1'b0;
		@(posedge clock);
		chk(reg_rdata, e);
	endtask : rdc
	task automatic do_reset(input logic f, input logic t);
		rst <= 1'b1;
		fiber_strap <= f;
		fault_strap <= t;
		cyc(20);
		rst <= 1'b0;
	endtask : do_reset
	// counts fault zeros and the ones between the first two of them
	task automatic ff_count();
		n = 0;
		z = 0;
		repeat (400) begin
			@(posedge clock);
			if (z == 1 && fiber_idle_bit === 1'b1 && mac_tx_clk_en === 1'b1) n++;
			if (fiber_idle_bit === 1'b0 && mac_tx_clk_en === 1'b1) z++;
		end
	endtask : ff_count
	task automatic print_verdict();
		$display("compares %0d fail_count %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : print_verdict
	initial begin
		forever #10 clock = ~clock;
	end
	initial begin
		cyc(20000);
		fail_count++;
		print_verdict();
	end
	initial begin
		for (int i = 0; i < 3; i++) begin
			energy_sense_strap <= i == 1;
			do_reset(i > 0, i == 2);
			rdc(REG_SCTL, {10'h000, i == 1, 3'h0, i > 0, i != 2});
		end
		remote_fault <= 1'b1;
		fiber_signal_detect <= 1'b1;
		ff_count();
		chk(16'(n), 16'h0054);
		chk({15'h0000, link_up}, 16'h0001);
		wr(REG_SCTL, 16'h0003);
		ff_count();
		chk(16'(z), 16'h0000);
		remote_fault <= 1'b0;
		$display("test strap and fault done");
		do_reset(1'b0, 1'b0);
		rdc(REG_CTRL, CTRL_RST);
		rdc(REG_NPTX, NPTX_RST);
		wr(5'h1f, 16'hffff);
		rdc(5'h1f, 16'h0000);
		chk(tx_page, ADV_RST);
		wr(REG_ADV, 16'h0061);
		cyc(2);
		chk(tx_page, ADV_RST);
		wr(REG_CTRL, 16'h3300);
		cyc(3);
		chk(tx_page, 16'h0061);
		@(posedge clock);
		rx_page <= 16'h0141;
		rx_page_valid <= 1'b1;
		@(posedge clock);
		rx_page_valid <= 1'b0;
		cyc(3);
		chk({14'h0000, speed100, full_duplex}, 16'h0001);
		rdc(REG_LPA, 16'h0141);
		rdc(REG_STAT, 16'h0028);
		rdc(REG_SSTAT, 16'h3800);
		rdc(REG_SSTAT, 16'h2800);
		wr(REG_CTRL, 16'h3300);
		legacy_speed100 <= 1'b1;
		legacy_detect <= 1'b1;
		@(posedge clock);
		legacy_detect <= 1'b0;
		cyc(3);
		chk({14'h0000, speed100, full_duplex}, 16'h0002);
		$display("test negotiation done");
		wr(REG_CTRL, 16'h2100);
		cyc(2);
		chk({14'h0000, speed100, full_duplex}, 16'h0002);
		wr(REG_CTRL, 16'h2300);
		cyc(3);
		chk({12'h000, scrambler_on, flp_tx_en, speed100, full_duplex}, 16'h000b);
		rx_idle_lock <= 1'b1;
		cyc(3);
		chk({15'h0000, link_up}, 16'h0001);
		rx_idle_lock <= 1'b0;
		wr(REG_SCTL, 16'h0401);
		cyc(3);
		chk({15'h0000, link_up}, 16'h0001);
		wr(REG_SCTL, 16'h0005);
		wr(REG_CTRL, 16'h0300);
		n = 0;
		repeat (60) @(posedge clock) if (nlp_tx === 1'b1) n++;
		chk(16'(n), 16'h0000);
		wr(REG_SCTL, 16'h0001);
		cyc(5);
		n = 0;
		repeat (60) @(posedge clock) if (nlp_tx === 1'b1) n++;
		chk(16'(n), 16'h0003);
		active <= 1'b1;
		cyc(40);
		chk({15'h0000, link_up}, 16'h0001);
		active <= 1'b0;
		cyc(80);
		chk({15'h0000, link_up}, 16'h0000);
		$display("test forced mode and link done");
		active <= 1'b1;
		mac_tx_en_in <= 1'b1;
		wr(REG_CTRL, 16'h0800);
		cyc(40);
		chk({14'h0000, link_up, mac_tx_en}, 16'h0000);
		wr(REG_CTRL, 16'h0000);
		cyc(40);
		chk({14'h0000, link_up, mac_tx_en}, 16'h0003);
		wr(REG_SCTL, 16'h0021);
		active <= 1'b0;
		cyc(80);
		rdc(REG_SSTAT, 16'h0200);
		n = 0;
		repeat (80) @(posedge clock) if (nlp_tx === 1'b1) n++;
		chk(16'(n), 16'h0002);
		energy_present <= 1'b1;
		cyc(3);
		rdc(REG_SSTAT, 16'h0000);
		rdc(REG_SCTL, 16'h0021);
		$display("test power down and sleep done");
		print_verdict();
	end
endmodule : tb_top
